// ---- core/tfc_pkg.sv ----
package tfc_pkg;
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEN_W = 11;
  localparam int STAT_W = 16;
  localparam int ARB_N = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_HW_CONF = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TX_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CSUM_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MAC_CR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FRM_CNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ERR_CNT = 8'h1c;

  // Field positions
  localparam int HW_STALL_DIS_BIT = 0;
  localparam int TXC_ON_BIT = 0;
  localparam int TXC_STOP_BIT = 1;
  localparam int TXC_FLUSH_BIT = 2;
  localparam int INT_TXERR_BIT = 0;
  localparam int INT_UNDER_BIT = 1;
  localparam int INT_STOP_BIT = 2;
  localparam int COE_EN_BIT = 0;
  localparam int MAC_DEFER_CHK_BIT = 0;
  localparam int MAC_TX_EN_BIT = 1;
  localparam int CMDB_CSUM_BIT = 14;

  // Transmit status word positions
  localparam int ST_ERRSUM_BIT = 15;
  localparam int ST_LOC_BIT = 11;
  localparam int ST_NOC_BIT = 10;
  localparam int ST_LATE_BIT = 9;
  localparam int ST_EXC_BIT = 8;
  localparam int ST_CNT_LSB = 3;
  localparam int ST_CNT_W = 4;
  localparam int ST_EXDEF_BIT = 2;
  localparam int ST_UNDER_BIT = 1;
  localparam int ST_DEFER_BIT = 0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_INT = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Arbiter requester indices, highest priority first
  localparam int ARB_USB_OUT = 0;
  localparam int ARB_USB_IN = 1;
  localparam int ARB_MAC_RX = 2;
  localparam int ARB_MAC_TX = 3;

  typedef struct packed {
    logic first_seg;
    logic last_seg;
    logic [LEN_W-1:0] buf_len;
    logic [DATA_W-1:0] cmd_b;
  } tfc_cmd_type;

  typedef struct packed {
    logic loss_carrier;
    logic no_carrier;
    logic late_coll;
    logic exc_coll;
    logic [ST_CNT_W-1:0] coll_cnt;
    logic exc_defer;
    logic underrun;
    logic deferred;
  } tfc_mac_stat_type;
endpackage

// ---- core/tfc_tx_frame_checker.sv ----
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Second command word constant per frame except checksum
// (RULE2) Buffer length total must equal frame length
// (RULE3) Frame opening buffer must carry first marker
// (RULE4) First marker mid-frame below size is error
// (RULE5) Reaching frame size demands last marker
// (RULE6) Last marker below frame size is error
// (RULE7) Zero buffer length is error
// (RULE8) Error stalls bulk OUT unless disabled
// (RULE9) Host resets device after transmit error
// (RULE10) MAC status word updates statistics, interrupts
// (RULE11) Bit 15 ORs the six error bits
// (RULE12) Bits 11, 10, 0 carrier and deferral
// (RULE13) Bit 9 reports late collision abort
// (RULE14) Bit 8 reports excessive collisions abort
// (RULE15) Bits 6:3 collision count, invalid on excess
// (RULE16) Bit 2 excessive deferral when checking enabled
// (RULE17) Bit 1 underrun, also sets underrun flag
// (RULE18) Preamble only with first, checksum, engine
// (RULE19) Flush resets pointers then clears flush bit
// (RULE20) Stop finishes frame, clears bits, pulses interrupt
// (RULE21) Restart needs on bit and MAC enable
// (RULE22) Fixed priority FIFO arbitration, OUT first
// (RULE23) Reserved status zero, size resets per frame
module tfc_tx_frame_checker #(
  parameter int STAT_CNT_W = tfc_pkg::STAT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [tfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tfc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tfc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Buffer command words
  input wire logic cmd_valid,
  input wire tfc_pkg::tfc_cmd_type cmd,
  // Checker results
  output logic tx_error_flag,
  output logic stall_out_pipe,
  output logic csum_preamble_pulse,
  // MAC status
  input wire logic mac_stat_valid,
  input wire tfc_pkg::tfc_mac_stat_type mac_stat,
  input wire logic mac_tx_busy,
  output logic [tfc_pkg::DATA_W-1:0] tx_status_word,
  output logic tx_status_pulse,
  output logic tx_fifo_underrun_flag,
  output logic transmitter_stopped_interrupt,
  // FIFO control
  output logic fifo_ptr_reset,
  output logic tx_run,
  // Arbiter
  input wire logic [tfc_pkg::ARB_N-1:0] arb_req,
  output logic [tfc_pkg::ARB_N-1:0] arb_grant
);
  import tfc_pkg::*;

  // Bus state
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff, rd_word;
  logic [1:0] rresp_ff;

  // Control and status
  logic stall_dis_ff, coe_en_ff, defer_chk_ff, mac_mac_transmit_enable_ff;
  logic tx_on_ff, nxt_tx_on, stop_ff, nxt_stop, flush_ff, nxt_flush;
  logic [2:0] interrupt_status_reg_ff, nxt_interrupt_status_reg, int_set, int_clr;
  logic [DATA_W-1:0] stat_word_ff, stat_build;
  logic stat_pulse_ff, stop_pulse_ff, ptr_reset_ff, run_ff, stall_ff;
  logic csum_ff;
  logic [STAT_CNT_W-1:0] frm_cnt_ff, err_cnt_ff;
  logic [ARB_N-1:0] grant_ff, nxt_grant;

  // Checker state
  logic expect_first_ff, nxt_expect_first;
  logic [LEN_W-1:0] acc_ff, nxt_acc, frame_len_ff;
  logic [DATA_W-1:0] cmdb_ref_ff;

  // Write channel handshakes; the register write waits for both halves
  wire aw_fire = s_axi_awvalid & awready_ff;
  wire w_fire = s_axi_wvalid & wready_ff;
  wire do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire ar_fire = s_axi_arvalid & arready_ff;
  wire lane0 = wstrb_ff[0];

  wire wr_hw = do_wr & lane0 & (aw_addr_ff == OFS_HW_CONF);
  wire wr_txc = do_wr & lane0 & (aw_addr_ff == OFS_TX_CFG);
  wire wr_int = do_wr & lane0 & (aw_addr_ff == OFS_IRQ_STAT);
  wire wr_coe = do_wr & lane0 & (aw_addr_ff == OFS_CSUM_CTRL);
  wire wr_mac = do_wr & lane0 & (aw_addr_ff == OFS_MAC_CR);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_ERR_CNT);
  endfunction

  wire wr_ok = mapped(aw_addr_ff);
  wire rd_ok = mapped(s_axi_araddr);

  always_comb begin
    nxt_aw_held = (aw_held_ff & ~do_wr) | aw_fire;
    nxt_w_held = (w_held_ff & ~do_wr) | w_fire;
    nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
    nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
    nxt_wready = ~nxt_w_held & ~nxt_bvalid;
    nxt_rvalid = ar_fire | (rvalid_ff & ~s_axi_rready);
    nxt_arready = ~nxt_rvalid;
  end

  always_comb begin
    rd_word = RST_WORD;
    unique case (s_axi_araddr)
      OFS_HW_CONF: rd_word[HW_STALL_DIS_BIT] = stall_dis_ff;
      OFS_TX_CFG: begin
        rd_word[TXC_ON_BIT] = tx_on_ff;
        rd_word[TXC_STOP_BIT] = stop_ff;
        rd_word[TXC_FLUSH_BIT] = flush_ff;
      end
      OFS_IRQ_STAT: rd_word[2:0] = interrupt_status_reg_ff;
      OFS_CSUM_CTRL: rd_word[COE_EN_BIT] = coe_en_ff;
      OFS_MAC_CR: begin
        rd_word[MAC_DEFER_CHK_BIT] = defer_chk_ff;
        rd_word[MAC_TX_EN_BIT] = mac_mac_transmit_enable_ff;
      end
      OFS_TX_STAT: rd_word = stat_word_ff;
      OFS_FRM_CNT: rd_word[STAT_CNT_W-1:0] = frm_cnt_ff;
      OFS_ERR_CNT: rd_word[STAT_CNT_W-1:0] = err_cnt_ff;
      default: rd_word = RST_WORD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      wdata_ff <= RST_WORD;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= RST_WORD;
      rresp_ff <= RESP_OKAY;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      if (aw_fire) aw_addr_ff <= s_axi_awaddr;
      if (w_fire) wdata_ff <= s_axi_wdata;
      if (w_fire) wstrb_ff <= s_axi_wstrb;
      bvalid_ff <= nxt_bvalid;
      if (do_wr) bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      if (ar_fire) rdata_ff <= rd_word;
      if (ar_fire) rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Buffer consistency check
  wire start = cmd.first_seg | expect_first_ff;
  wire [DATA_W-1:0] ck_mask = DATA_W'(1) << CMDB_CSUM_BIT;
  wire [DATA_W-1:0] cmdb_masked = cmd.cmd_b & ~ck_mask;
  wire [LEN_W-1:0] cur_flen = start ? cmd.cmd_b[LEN_W-1:0] : frame_len_ff;
  wire [LEN_W-1:0] base = start ? '0 : acc_ff;
  wire [LEN_W:0] sum = {1'b0, base} + {1'b0, cmd.buf_len};
  wire reach = sum >= {1'b0, cur_flen};
  wire err_cmdb = ~start & (cmdb_masked != cmdb_ref_ff); // RULE1
  wire err_size = cmd.last_seg & (sum != {1'b0, cur_flen}); // RULE2
  wire err_no_first = expect_first_ff & ~cmd.first_seg; // RULE3
  wire err_unexp_first = ~expect_first_ff & cmd.first_seg
    & (acc_ff < frame_len_ff); // RULE4
  wire err_no_last = reach & ~cmd.last_seg; // RULE5
  wire err_unexp_last = cmd.last_seg & ~reach; // RULE6
  wire err_zero = cmd.buf_len == '0; // RULE7
  wire cmd_err = cmd_valid & (err_cmdb | err_size | err_no_first
    | err_unexp_first | err_no_last | err_unexp_last | err_zero);
  // Frame closes on last marker or on reaching size, so a lost marker
  // cannot drag the next frame's buffers into this one
  wire frame_end = cmd.last_seg | reach;

  always_comb begin
    nxt_expect_first = expect_first_ff;
    nxt_acc = acc_ff;
    if (cmd_valid) begin
      nxt_expect_first = frame_end;
      nxt_acc = frame_end ? '0 : sum[LEN_W-1:0]; // RULE23
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expect_first_ff <= 1'b1;
      acc_ff <= '0;
      frame_len_ff <= '0;
      cmdb_ref_ff <= RST_WORD;
      stall_ff <= 1'b0;
      csum_ff <= 1'b0;
    end else begin
      expect_first_ff <= nxt_expect_first;
      acc_ff <= nxt_acc;
      if (cmd_valid & start) frame_len_ff <= cmd.cmd_b[LEN_W-1:0];
      if (cmd_valid & start) cmdb_ref_ff <= cmdb_masked;
      // Held until device reset, the only recovery
      stall_ff <= stall_ff | (cmd_err & ~stall_dis_ff); // RULE8
      csum_ff <= cmd_valid & cmd.first_seg
        & cmd.cmd_b[CMDB_CSUM_BIT] & coe_en_ff; // RULE18
    end
  end

  // Status word built from MAC fields, reserved bits zero
  wire exdef_q = mac_stat.exc_defer & defer_chk_ff; // RULE16
  wire err_sum = mac_stat.loss_carrier | mac_stat.no_carrier
    | mac_stat.late_coll | mac_stat.exc_coll | exdef_q
    | mac_stat.underrun; // RULE11

  always_comb begin
    stat_build = RST_WORD; // RULE23
    stat_build[ST_ERRSUM_BIT] = err_sum;
    stat_build[ST_LOC_BIT] = mac_stat.loss_carrier; // RULE12
    stat_build[ST_NOC_BIT] = mac_stat.no_carrier; // RULE12
    stat_build[ST_LATE_BIT] = mac_stat.late_coll; // RULE13
    stat_build[ST_EXC_BIT] = mac_stat.exc_coll; // RULE14
    // Count is meaningless after an excessive abort, so report zero
    stat_build[ST_CNT_LSB +: ST_CNT_W] =
      mac_stat.exc_coll ? '0 : mac_stat.coll_cnt; // RULE15
    stat_build[ST_EXDEF_BIT] = exdef_q;
    stat_build[ST_UNDER_BIT] = mac_stat.underrun; // RULE17
    stat_build[ST_DEFER_BIT] = mac_stat.deferred; // RULE12
  end

  // Stop completes on the frame's status, or at once when idle
  wire stop_done = stop_ff & (mac_stat_valid | ~mac_tx_busy); // RULE20
  wire flush_go = flush_ff & ~ptr_reset_ff;

  always_comb begin
    int_set = 3'h0;
    int_set[INT_TXERR_BIT] = cmd_err;
    int_set[INT_UNDER_BIT] = mac_stat_valid & mac_stat.underrun; // RULE17
    int_set[INT_STOP_BIT] = stop_done;
    int_clr = wr_int ? wdata_ff[2:0] : 3'h0;
    // A new event wins over a same-cycle clear
    nxt_interrupt_status_reg = (interrupt_status_reg_ff & ~int_clr) | int_set; // RULE10
    nxt_tx_on = wr_txc ? wdata_ff[TXC_ON_BIT] : (tx_on_ff & ~stop_done);
    nxt_stop = (stop_ff & ~stop_done)
      | (wr_txc & wdata_ff[TXC_STOP_BIT]); // RULE20
    nxt_flush = (flush_ff & ~ptr_reset_ff)
      | (wr_txc & wdata_ff[TXC_FLUSH_BIT]); // RULE19
  end

  // Fixed priority, lowest index wins
  always_comb begin
    nxt_grant = '0;
    for (int i = ARB_N - 1; i >= 0; i--) begin
      if (arb_req[i]) begin
        nxt_grant = '0;
        nxt_grant[i] = 1'b1; // RULE22
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_dis_ff <= 1'b0;
      coe_en_ff <= 1'b0;
      defer_chk_ff <= 1'b0;
      mac_mac_transmit_enable_ff <= 1'b0;
      tx_on_ff <= 1'b0;
      stop_ff <= 1'b0;
      flush_ff <= 1'b0;
      interrupt_status_reg_ff <= RST_INT;
      stat_word_ff <= RST_WORD;
      stat_pulse_ff <= 1'b0;
      stop_pulse_ff <= 1'b0;
      ptr_reset_ff <= 1'b0;
      run_ff <= 1'b0;
      frm_cnt_ff <= '0;
      err_cnt_ff <= '0;
      grant_ff <= '0;
    end else begin
      if (wr_hw) stall_dis_ff <= wdata_ff[HW_STALL_DIS_BIT];
      if (wr_coe) coe_en_ff <= wdata_ff[COE_EN_BIT];
      if (wr_mac) defer_chk_ff <= wdata_ff[MAC_DEFER_CHK_BIT];
      if (wr_mac) mac_mac_transmit_enable_ff <= wdata_ff[MAC_TX_EN_BIT];
      tx_on_ff <= nxt_tx_on;
      stop_ff <= nxt_stop;
      flush_ff <= nxt_flush;
      interrupt_status_reg_ff <= nxt_interrupt_status_reg;
      if (mac_stat_valid) stat_word_ff <= stat_build; // RULE10
      stat_pulse_ff <= mac_stat_valid;
      stop_pulse_ff <= stop_done; // RULE20
      ptr_reset_ff <= flush_go; // RULE19
      // Unflushed frames simply drain once both enables are back
      run_ff <= nxt_tx_on & mac_mac_transmit_enable_ff; // RULE21
      if (mac_stat_valid) frm_cnt_ff <= frm_cnt_ff + 1'b1;
      if (mac_stat_valid & err_sum) err_cnt_ff <= err_cnt_ff + 1'b1;
      grant_ff <= nxt_grant;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign tx_error_flag = interrupt_status_reg_ff[INT_TXERR_BIT];
  assign stall_out_pipe = stall_ff;
  assign csum_preamble_pulse = csum_ff;
  assign tx_status_word = stat_word_ff;
  assign tx_status_pulse = stat_pulse_ff;
  assign tx_fifo_underrun_flag = interrupt_status_reg_ff[INT_UNDER_BIT];
  assign transmitter_stopped_interrupt = stop_pulse_ff;
  assign fifo_ptr_reset = ptr_reset_ff;
  assign tx_run = run_ff;
  assign arb_grant = grant_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CMDB_MISMATCH: assert property ( // RULE1
    cmd_valid && !start && (cmdb_masked != cmdb_ref_ff) |=> tx_error_flag)
    else $error("command B mismatch not flagged");
  AST_SIZE_MISMATCH: assert property ( // RULE2
    cmd_valid && cmd.last_seg && (sum != {1'b0, cur_flen})
    |=> tx_error_flag)
    else $error("frame size mismatch not flagged");
  AST_MISSING_FIRST: assert property ( // RULE3
    cmd_valid && expect_first_ff && !cmd.first_seg |=> tx_error_flag)
    else $error("missing first marker not flagged");
  AST_MISSING_LAST: assert property ( // RULE5
    cmd_valid && reach && !cmd.last_seg |=> tx_error_flag ##0
    expect_first_ff)
    else $error("missing last marker not flagged");
  AST_ZERO_LEN: assert property ( // RULE7
    cmd_valid && cmd.buf_len == '0 |=> tx_error_flag)
    else $error("zero length not flagged");
  AST_STALL: assert property ( // RULE8
    cmd_err && !stall_dis_ff |=> stall_out_pipe [*3])
    else $error("out pipe not stalled");
  AST_ERRSUM_OR: assert property ( // RULE11
    tx_status_pulse |-> tx_status_word[ST_ERRSUM_BIT] ==
    (|{tx_status_word[11:8], tx_status_word[2:1]}))
    else $error("error summary bit wrong");
  AST_RSVD_ZERO: assert property ( // RULE23
    tx_status_pulse |-> tx_status_word[31:16] == '0
    && tx_status_word[14:12] == '0 && !tx_status_word[7])
    else $error("reserved status bits set");
  AST_UNDERRUN: assert property ( // RULE17
    mac_stat_valid && mac_stat.underrun |=> tx_fifo_underrun_flag
    && tx_status_word[ST_UNDER_BIT])
    else $error("underrun flag missing");
  AST_STOP_PULSE: assert property ( // RULE20
    stop_ff && mac_stat_valid |=> transmitter_stopped_interrupt
    ##1 !transmitter_stopped_interrupt)
    else $error("stop interrupt not a single pulse");
  AST_FLUSH_SEQ: assert property ( // RULE19
    $rose(flush_ff) |-> ##1 fifo_ptr_reset ##1 !fifo_ptr_reset)
    else $error("flush sequence wrong");
  AST_ARB_PRIO: assert property ( // RULE22
    arb_req[ARB_USB_OUT] |=> arb_grant == 4'h1)
    else $error("bulk OUT not granted first");
  AST_CSUM: assert property ( // RULE18
    csum_preamble_pulse |-> $past(cmd_valid) && $past(cmd.first_seg))
    else $error("preamble without first marker");

  COV_GOOD_FRAME: cover property (
    cmd_valid && cmd.first_seg && !cmd_err ##[1:20]
    cmd_valid && cmd.last_seg && !cmd_err);
  COV_ERROR: cover property (cmd_err ##1 stall_out_pipe);
  COV_STOP: cover property (stop_ff && mac_tx_busy ##[1:50] stop_done);
  COV_FLUSH: cover property (fifo_ptr_reset);
endmodule // tfc_tx_frame_checker

// ---- tb/tfc_mac_model.sv ----
`timescale 1ns/10ps
module tfc_mac_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Frame request from the bench
  input wire logic go,
  input wire tfc_pkg::tfc_mac_stat_type go_stat,
  input wire logic [7:0] go_dly,
  // Toward the block
  output logic mac_tx_busy,
  output logic mac_stat_valid,
  output tfc_pkg::tfc_mac_stat_type mac_stat
);
  import tfc_pkg::*;
  tfc_mac_stat_type stat_ff;
  logic [7:0] cnt_ff;
  // Off the valid cycle the word is scrambled, never a stale copy
  assign mac_stat = mac_stat_valid ? stat_ff : ~stat_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_tx_busy <= 1'b0;
      mac_stat_valid <= 1'b0;
      cnt_ff <= 8'h00;
      stat_ff <= '0;
    end else begin
      mac_stat_valid <= 1'b0;
      if (go && !mac_tx_busy) begin
        mac_tx_busy <= 1'b1;
        cnt_ff <= go_dly;
        stat_ff <= go_stat;
      end else if (mac_tx_busy) begin
        cnt_ff <= cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
          // One status per frame, aborted ones too
          mac_tx_busy <= 1'b0;
          mac_stat_valid <= 1'b1;
        end
      end
    end
  end
endmodule // tfc_mac_model

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import tfc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmd_valid, tx_error_flag;
  logic stall_out_pipe, csum_preamble_pulse, mac_stat_valid, mac_tx_busy;
  logic tx_status_pulse, tx_fifo_underrun_flag, fifo_ptr_reset, tx_run;
  logic transmitter_stopped_interrupt, go, coe_en, und_exp;
  logic [7:0] awaddr, araddr, go_dly;
  logic [31:0] wdata, rdata, tx_status_word, rd;
  logic [3:0] wstrb, arb_req, arb_grant;
  logic [1:0] bresp, rresp, rsp;
  tfc_cmd_type cmd;
  tfc_mac_stat_type mac_stat, go_stat, s;
  logic [31:0] lfsr = 32'h0001_6167; // seed 90471
  int fail_count = 0;
  int cmp_count = 0;
  int stop_cnt = 0;
  int ptr_cnt = 0;
  int err_exp = 0;

  tfc_tx_frame_checker u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmd_valid(cmd_valid), .cmd(cmd),
    .tx_error_flag(tx_error_flag), .stall_out_pipe(stall_out_pipe),
    .csum_preamble_pulse(csum_preamble_pulse),
    .mac_stat_valid(mac_stat_valid), .mac_stat(mac_stat),
    .mac_tx_busy(mac_tx_busy), .tx_status_word(tx_status_word),
    .tx_status_pulse(tx_status_pulse),
    .tx_fifo_underrun_flag(tx_fifo_underrun_flag),
    .transmitter_stopped_interrupt(transmitter_stopped_interrupt),
    .fifo_ptr_reset(fifo_ptr_reset), .tx_run(tx_run),
    .arb_req(arb_req), .arb_grant(arb_grant));

  tfc_mac_model u_mac (.aclk(aclk), .aresetn(aresetn), .go(go),
    .go_stat(go_stat), .go_dly(go_dly), .mac_tx_busy(mac_tx_busy),
    .mac_stat_valid(mac_stat_valid), .mac_stat(mac_stat));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(negedge aclk) begin
    if (transmitter_stopped_interrupt === 1'b1) stop_cnt++;
    if (fifo_ptr_reset === 1'b1) ptr_cnt++;
  end

  task report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far above the planned run length
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    report_and_stop;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task rnd;
    lfsr = lfsr_step(lfsr);
  endtask

  function automatic logic [31:0] exp_stat(tfc_mac_stat_type t, logic dc);
    logic [31:0] w;
    w = 32'h0;
    w[11] = t.loss_carrier;
    w[10] = t.no_carrier;
    w[9] = t.late_coll;
    w[8] = t.exc_coll;
    w[6:3] = t.exc_coll ? 4'h0 : t.coll_cnt;
    w[2] = t.exc_defer & dc;
    w[1] = t.underrun;
    w[0] = t.deferred;
    w[15] = w[11] | w[10] | w[9] | w[8] | w[2] | w[1];
    return w;
  endfunction

  function automatic logic [3:0] exp_grant(logic [3:0] r);
    if (r[0]) return 4'h1;
    if (r[1]) return 4'h2;
    if (r[2]) return 4'h4;
    if (r[3]) return 4'h8;
    return 4'h0;
  endfunction

  // Leading edge keeps two calls from driving in one time step
  task axi_wr(input logic [7:0] a, input logic [31:0] d,
              output logic [1:0] r);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] m,
              input logic [31:0] e);
    axi_rd(a, rd, rsp);
    chk(rd & m, e);
  endtask

  task do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task send(input logic f, input logic l, input logic [10:0] n,
            input logic [31:0] b);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{first_seg: f, last_seg: l, buf_len: n, cmd_b: b};
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
    @(negedge aclk);
    chk(csum_preamble_pulse, f & b[14] & coe_en);
  endtask

  task run_case(input int k);
    logic [10:0] fl, a;
    logic [31:0] b;
    logic e;
    do_reset;
    chk(tx_error_flag | stall_out_pipe, 1'b0);
    rnd;
    fl = 11'(32 + lfsr[9:0]);
    a = 11'(1 + lfsr[13:10]);
    b = {17'h0, lfsr[21:19], 1'b0, fl};
    coe_en = lfsr[22];
    axi_wr(OFS_HW_CONF, {31'h0, k[0]}, rsp);
    axi_wr(OFS_CSUM_CTRL, {31'h0, coe_en}, rsp);
    e = 1'b1;
    case (k)
      0: begin
        send(1, 1, fl, b);
        send(1, 1, fl, b);
        e = 1'b0;
      end
      1: begin
        send(1, 0, a, b);
        send(0, 0, a, b ^ 32'h4000);
        send(0, 1, fl - 2 * a, b ^ 32'h4000);
        e = 1'b0;
      end
      2: begin
        send(1, 0, a, b);
        send(0, 1, fl - a, b ^ 32'h1000);
      end
      3: send(0, 1, fl, b);
      4: begin
        send(1, 0, a, b);
        send(1, 1, fl - a, b);
      end
      5: send(1, 0, fl, b);
      6: send(1, 1, fl - 11'h1, b);
      7: send(1, 1, 11'h0, b);
      default: begin
        send(1, 0, a, b);
        send(0, 1, fl, b);
      end
    endcase
    repeat (2) @(negedge aclk);
    chk(tx_error_flag, e);
    chk(stall_out_pipe, e & !k[0]);
    rd_chk(OFS_IRQ_STAT, 32'h1, {31'h0, e});
  endtask

  task stat_case(input tfc_mac_stat_type t, input logic dc,
                 input logic [7:0] dly);
    axi_wr(OFS_MAC_CR, {31'h0, dc}, rsp);
    @(posedge aclk);
    go <= 1'b1;
    go_stat <= t;
    go_dly <= dly;
    @(posedge aclk);
    go <= 1'b0;
    do @(negedge aclk); while (tx_status_pulse !== 1'b1);
    chk(tx_status_word, exp_stat(t, dc));
    rd = exp_stat(t, dc);
    err_exp += rd[15];
    und_exp = und_exp | t.underrun;
    @(negedge aclk);
    chk(tx_fifo_underrun_flag, und_exp);
    rd_chk(OFS_TX_STAT, 32'hffff_ffff, exp_stat(t, dc));
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cmd_valid, go} = 7'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    cmd = '0;
    go_stat = '0;
    go_dly = 8'h0;
    arb_req = 4'h0;
    coe_en = 1'b0;
    und_exp = 1'b0;
    do_reset;
    rd_chk(OFS_HW_CONF, 32'hffff_ffff, RST_WORD);
    rd_chk(OFS_TX_CFG, 32'hffff_ffff, RST_WORD);
    for (int k = 0; k < 9; k++) run_case(k);
    do_reset;
    stat_case('0, 1'b1, 8'h2);
    s = '0;
    s.exc_coll = 1'b1;
    s.coll_cnt = 4'hf;
    s.exc_defer = 1'b1;
    stat_case(s, 1'b0, 8'h0);
    repeat (12) begin
      rnd;
      stat_case(tfc_mac_stat_type'(lfsr[10:0]), lfsr[11],
                {4'h0, lfsr[15:12]});
    end
    rd_chk(OFS_FRM_CNT, 32'hffff_ffff, 32'd14);
    rd_chk(OFS_ERR_CNT, 32'hffff_ffff, err_exp);
    // Stop while a frame is still on the wire
    axi_wr(OFS_MAC_CR, 32'h2, rsp);
    axi_wr(OFS_TX_CFG, 32'h1, rsp);
    @(negedge aclk);
    chk(tx_run, 1'b1);
    @(posedge aclk);
    go <= 1'b1;
    go_dly <= 8'h28;
    @(posedge aclk);
    go <= 1'b0;
    axi_wr(OFS_TX_CFG, 32'h3, rsp);
    chk(stop_cnt, 0);
    do @(negedge aclk); while (tx_status_pulse !== 1'b1);
    repeat (2) @(negedge aclk);
    chk(stop_cnt, 1);
    chk(tx_run, 1'b0);
    rd_chk(OFS_TX_CFG, 32'h3, 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4);
    axi_wr(OFS_TX_CFG, 32'h4, rsp);
    repeat (4) @(negedge aclk);
    chk(ptr_cnt, 1);
    rd_chk(OFS_TX_CFG, 32'h4, 32'h0);
    axi_wr(OFS_TX_CFG, 32'h1, rsp);
    @(negedge aclk);
    chk(tx_run, 1'b1);
    axi_wr(OFS_MAC_CR, 32'h0, rsp);
    @(negedge aclk);
    chk(tx_run, 1'b0);
    axi_wr(OFS_IRQ_STAT, 32'h7, rsp);
    rd_chk(OFS_IRQ_STAT, 32'h7, 32'h0);
    axi_wr(8'h40, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    axi_rd(8'h40, rd, rsp);
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < 20; i++) begin
      rnd;
      s[3:0] = (i < 4) ? 4'hf << i : lfsr[3:0];
      @(posedge aclk);
      arb_req <= s[3:0];
      @(posedge aclk);
      @(negedge aclk);
      chk(arb_grant, exp_grant(s[3:0]));
    end
    report_and_stop;
  end
endmodule // tb_top
